// >>> hlie_defines.svh
// Constants for the hardware loop and interrupt entry sequencer.
// Assumes a 16-bit program address and a single 200 MHz core clock.
`ifndef HLIE_DEFINES_SVH
`define HLIE_DEFINES_SVH
`define HLIE_ADDR_W 16
`define HLIE_MODE_W 16
`define HLIE_LOOP_INH_BIT 7
`define HLIE_VEC_LO 16'h0020
`define HLIE_VEC_HI 16'h003f
`define HLIE_LE_RESET 16'hffff
`define HLIE_RESET_VEC 16'h0000
`define HLIE_HOLD_INSTRS 3
`endif

// >>> hlie_pkg.sv
// Types for the hardware loop and interrupt entry sequencer.
// Assumes hlie_defines.svh is on the include path.
`include "hlie_defines.svh"
package hlie_pkg;
  typedef enum logic [5:0] {
    HLIE_IDLE = 6'h01,
    HLIE_C1 = 6'h02,
    HLIE_C2 = 6'h04,
    HLIE_C3 = 6'h08,
    HLIE_C4 = 6'h10,
    HLIE_C5 = 6'h20
  } hlie_state_t;
  // Class of the instruction in decode
  typedef struct packed {
    logic jump;
    logic cond_jump;
    logic cond_indirect_jump;
    logic return_from_interrupt;
    logic loop_start;
    logic call;
    logic vector_jump_cancel_slot;
  } hlie_class_t;
  // Software load of a control register
  typedef struct packed {
    logic wr_loop_start;
    logic wr_loop_end;
    logic wr_loop_count;
    logic wr_return_link;
    logic wr_mode;
    logic [`HLIE_ADDR_W-1:0] data;
  } hlie_load_t;
endpackage

// >>> hlie_seq.sv
// Loop hardware and interrupt entry sequencer of the core's program control.
// Decode supplies class, jump target and operands; arbiter supplies vector.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`include "hlie_defines.svh"
module hlie_seq #(
  parameter int ADDR_W = `HLIE_ADDR_W,
  parameter int MODE_W = `HLIE_MODE_W,
  parameter bit HAS_LOOP = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire hlie_pkg::hlie_class_t dec_class,
  input wire logic jump_taken,
  input wire logic [ADDR_W-1:0] jump_target,
  input wire logic [ADDR_W-1:0] loop_end_operand,
  input wire logic [ADDR_W-1:0] loop_count_operand,
  input wire hlie_pkg::hlie_load_t sw_load,
  input wire logic [ADDR_W-1:0] page_in,
  input wire logic int_req,
  input wire logic [ADDR_W-1:0] int_vector,
  output logic [ADDR_W-1:0] fetch_addr,
  output logic cancel_exec,
  output logic [ADDR_W-1:0] loop_start_addr,
  output logic [ADDR_W-1:0] loop_end_addr,
  output logic [ADDR_W-1:0] loop_count,
  output logic [ADDR_W-1:0] interrupt_return_link,
  output logic [ADDR_W-1:0] saved_instr_page,
  output logic [MODE_W-1:0] mode_status_word,
  output logic [MODE_W-1:0] saved_mode_status,
  output logic int_busy
);
  import hlie_pkg::*;

  initial begin
    if (ADDR_W < 11 || ADDR_W > 20 || MODE_W < 8 || MODE_W > ADDR_W)
      $error("hlie_seq: unsupported widths");
  end

  localparam logic [ADDR_W-1:0] ONE = ADDR_W'(1);
  localparam int LI = `HLIE_LOOP_INH_BIT;

  hlie_state_t state_reg;
  logic [ADDR_W-1:0] fetch_reg, ls_reg, le_reg, lc_reg, lr_reg, page_reg;
  logic [MODE_W-1:0] mode_reg, shadow_reg;
  logic cancel_reg;
  logic prev_cof_reg;   // Instruction fetched before the current one was flow change
  logic c1_from_end_reg;
  logic loop_go_reg;    // Loop rewind decided at the cycle-one fetch
  logic [2:0] guard_reg;  // Routine instructions still to run before next entry
  logic busy_reg;  // Registered so the busy output comes straight from a flop

  logic is_cof, loop_hit, loop_rewind;
  logic [ADDR_W-1:0] seq_next, fetch_next, dest_addr;

  // Flow change set for cancel decision excludes call and vector jump
  assign is_cof = dec_class.jump | dec_class.cond_jump | dec_class.cond_indirect_jump |
                  dec_class.return_from_interrupt | dec_class.loop_start;

  assign loop_hit = HAS_LOOP && (fetch_reg == le_reg) && !mode_reg[LI];
  assign loop_rewind = loop_hit && (lc_reg != '0);
  // Zero count falls through to the next address
  assign seq_next = loop_rewind ? ls_reg : fetch_reg + ONE;

  // Destination of the instruction in execute during cycle two
  always_comb begin
    if (prev_cof_reg && jump_taken)
      dest_addr = jump_target;
    else if (c1_from_end_reg && loop_go_reg)
      dest_addr = ls_reg;
    else
      dest_addr = lr_reg + ONE;
  end

  always_comb begin
    case (state_reg)
      HLIE_C1: fetch_next = int_vector;
      default: fetch_next = (prev_cof_reg && jump_taken) ? jump_target : seq_next;
    endcase
  end

  // Entry machine, one step per instruction cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= HLIE_IDLE;
    end else begin
      case (state_reg)
        HLIE_IDLE: if (int_req && guard_reg == 3'h0) state_reg <= HLIE_C1;
        HLIE_C1: state_reg <= HLIE_C2;
        HLIE_C2: state_reg <= HLIE_C3;
        HLIE_C3: state_reg <= HLIE_C4;
        HLIE_C4: state_reg <= HLIE_C5;
        HLIE_C5: state_reg <= HLIE_IDLE;
        default: state_reg <= HLIE_IDLE;
      endcase
    end
  end

  // Busy mirrors the next state of the entry machine
  always_ff @(posedge ref_clk) begin
    if (rst)
      busy_reg <= 1'b0;
    else if (state_reg == HLIE_IDLE)
      busy_reg <= int_req && guard_reg == 3'h0;
    else
      busy_reg <= (state_reg != HLIE_C5);
  end

  // Hold-off after entry; idle reached after C5 which is cycle 5
  always_ff @(posedge ref_clk) begin
    if (rst)
      guard_reg <= 3'h0;
    else if (state_reg == HLIE_C2)
      guard_reg <= 3'(`HLIE_HOLD_INSTRS);
    else if (guard_reg == 3'h1 && is_cof)
      guard_reg <= 3'h1;
    else if (guard_reg != 3'h0 && state_reg == HLIE_IDLE)
      guard_reg <= guard_reg - 3'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fetch_reg <= ADDR_W'(`HLIE_RESET_VEC);
      prev_cof_reg <= 1'b0;
    end else begin
      fetch_reg <= fetch_next;
      prev_cof_reg <= is_cof && !cancel_reg;
    end
  end

  // Cycle-one facts captured for the cycle-two decision
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c1_from_end_reg <= 1'b0;
      loop_go_reg <= 1'b0;
    end else if (state_reg == HLIE_C1) begin
      c1_from_end_reg <= loop_hit;
      loop_go_reg <= loop_rewind;
    end
  end

  // Cancelled slot runs as a no-operation in decode and execute
  always_ff @(posedge ref_clk) begin
    if (rst)
      cancel_reg <= 1'b0;
    else
      cancel_reg <= (state_reg == HLIE_C2) && !prev_cof_reg && !c1_from_end_reg;
  end

  // Loop registers; the instruction path updates as the loop start leaves decode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ls_reg <= '0;
      le_reg <= '1;
      lc_reg <= '0;
    end else begin
      if (sw_load.wr_loop_start)
        ls_reg <= ADDR_W'(sw_load.data);
      else if (dec_class.loop_start && !cancel_reg)
        ls_reg <= fetch_reg + ONE;
      if (sw_load.wr_loop_end)
        le_reg <= ADDR_W'(sw_load.data);
      else if (dec_class.loop_start && !cancel_reg)
        le_reg <= loop_end_operand;
      if (sw_load.wr_loop_count)
        lc_reg <= ADDR_W'(sw_load.data);
      else if (dec_class.loop_start && !cancel_reg)
        lc_reg <= loop_count_operand;
      else if (loop_rewind && state_reg != HLIE_C1)
        lc_reg <= lc_reg - ONE;
      else if (state_reg == HLIE_C2 && loop_go_reg && c1_from_end_reg)
        lc_reg <= lc_reg - ONE;
    end
  end

  // Return link: software load wins over automatic capture
  always_ff @(posedge ref_clk) begin
    if (rst)
      lr_reg <= '0;
    else if (sw_load.wr_return_link)
      lr_reg <= ADDR_W'(sw_load.data);
    else if (state_reg == HLIE_C1)
      lr_reg <= fetch_reg;
    else if (state_reg == HLIE_C2 && (prev_cof_reg || c1_from_end_reg))
      lr_reg <= dest_addr;
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      page_reg <= '0;
    else if (state_reg == HLIE_C2)
      page_reg <= page_in;
  end

  // Mode word loop-inhibit handling
  always_ff @(posedge ref_clk) begin
    if (rst)
      mode_reg <= '0;
    else if (sw_load.wr_mode)
      mode_reg <= sw_load.data[MODE_W-1:0];
    else if (state_reg == HLIE_C2)
      mode_reg[LI] <= 1'b1;
    else if (!cancel_reg && (dec_class.jump | dec_class.cond_indirect_jump |
             dec_class.return_from_interrupt | dec_class.call | dec_class.loop_start))
      mode_reg[LI] <= 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      shadow_reg <= '0;
    else if (state_reg == HLIE_C4)
      shadow_reg <= mode_reg;
  end

  assign fetch_addr = fetch_reg;
  assign cancel_exec = cancel_reg;
  assign loop_start_addr = ls_reg;
  assign loop_end_addr = le_reg;
  assign loop_count = lc_reg;
  assign interrupt_return_link = lr_reg;
  assign saved_instr_page = page_reg;
  assign mode_status_word = mode_reg;
  assign saved_mode_status = shadow_reg;
  assign int_busy = busy_reg;

  a_c1_saves_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == HLIE_C1 && !sw_load.wr_return_link |=> lr_reg == $past(fetch_reg))
    else $error("return link not loaded in cycle one");
  a_c2_vector_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == HLIE_C1 |=> fetch_reg == $past(int_vector) && state_reg == HLIE_C2)
    else $error("vector not fetched in cycle two");
  a_five_cycle_seq: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == HLIE_C1 |=> state_reg == HLIE_C2 ##1 state_reg == HLIE_C3
    ##1 state_reg == HLIE_C4 ##1 state_reg == HLIE_C5 ##1 state_reg == HLIE_IDLE)
    else $error("entry sequence broken");
  a_inhibit_set: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == HLIE_C2 && !sw_load.wr_mode |=> mode_reg[LI])
    else $error("loop inhibit not set");
  a_shadow_copy: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == HLIE_C4 |=> shadow_reg == $past(mode_reg))
    else $error("mode shadow not copied");
  a_rewind_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    loop_rewind && state_reg != HLIE_C1 && !(prev_cof_reg && jump_taken)
    && !sw_load.wr_loop_start |=> fetch_reg == $past(ls_reg))
    else $error("loop did not rewind");
  a_end_fallthru: assert property (@(posedge ref_clk) disable iff (rst)
    loop_hit && lc_reg == '0 && state_reg == HLIE_IDLE && !(prev_cof_reg && jump_taken)
    |=> fetch_reg == $past(fetch_reg) + ONE)
    else $error("loop end did not fall through");
  a_inhibit_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg[LI] |-> !loop_rewind)
    else $error("loop detected while inhibited");
  a_sw_link_wins: assert property (@(posedge ref_clk) disable iff (rst)
    sw_load.wr_return_link |=> lr_reg == $past(sw_load.data))
    else $error("explicit link load lost");
  a_cancel_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == HLIE_C2 && !prev_cof_reg && !c1_from_end_reg && !sw_load.wr_return_link
    |=> cancel_reg && $stable(lr_reg))
    else $error("cancel path wrong");
  a_no_reentry: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == HLIE_C5 |=> state_reg == HLIE_IDLE [*3])
    else $error("re-entry too early");
endmodule // hlie_seq

// >>> hlie_arb_model.sv
// Behavioural interrupt arbiter driving the sequencer request and vector.
// Assumes the bench raises want for as long as a request should stand.
`timescale 1ns/10ps
module hlie_arb_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic want,
  output logic int_req,
  output logic [15:0] int_vector
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_req <= 1'b0;
      int_vector <= 16'h0000;
    end else if (want) begin
      int_req <= 1'b1;
      // Vector chosen once, then held while asking
      if (!int_req) int_vector <= 16'h0020 + 16'($urandom_range(0, 31));
    end else begin
      int_req <= 1'b0;
      // Idle vector toggles between the last vector and its inverse every cycle
      int_vector <= ~int_vector;
    end
  end
endmodule // hlie_arb_model

// >>> hlie_seq_tb_top.sv
// Self-checking bench for the loop and interrupt entry sequencer.
// Assumes hlie_pkg, hlie_seq and hlie_arb_model are compiled first.
`timescale 1ns/10ps
module hlie_seq_tb_top;
  import hlie_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic jump_taken = 1'b0;
  logic want = 1'b0;
  logic int_req, cancel_exec, int_busy;
  hlie_class_t dec_class = '0;
  hlie_load_t sw_load = '0;
  logic [15:0] jump_target = '0, end_op = '0, cnt_op = '0, page_in = '0;
  logic [15:0] int_vector, fetch_addr, lp_start, lp_end, lp_cnt, link, spage, mode, smode;
  int errors = 0, total_checks = 0, cyc = 0;
  int e, c, n, m, pg, f1;

  hlie_seq u_hlie_seq (.ref_clk(ref_clk), .rst(rst), .dec_class(dec_class),
    .jump_taken(jump_taken), .jump_target(jump_target), .loop_end_operand(end_op),
    .loop_count_operand(cnt_op), .sw_load(sw_load), .page_in(page_in), .int_req(int_req),
    .int_vector(int_vector), .fetch_addr(fetch_addr), .cancel_exec(cancel_exec),
    .loop_start_addr(lp_start), .loop_end_addr(lp_end), .loop_count(lp_cnt),
    .interrupt_return_link(link), .saved_instr_page(spage), .mode_status_word(mode),
    .saved_mode_status(smode), .int_busy(int_busy));
  hlie_arb_model u_hlie_arb_model (.ref_clk(ref_clk), .rst(rst), .want(want),
    .int_req(int_req), .int_vector(int_vector));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // Sets one write strobe; caller clears the bus after the last load
  task automatic load(input int k, input logic [15:0] d);
    hlie_load_t v;
    v = '0;
    v.data = d;
    v[16+k] = 1'b1;
    sw_load <= v;
    tick(1);
  endtask

  task automatic wait_busy(input logic lvl);
    n = 0;
    while (int_busy !== lvl && n < 30) begin
      tick(1);
      n++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(79));
    tick(8);
    check(fetch_addr, 16'h0000);
    check(lp_end, 16'hffff);
    check(lp_cnt, 16'h0000);
    check(mode, 16'h0000);
    check(int_busy, 1'b0);
    rst <= 1'b0;
    $display("reset test done");
    c = $urandom_range(1, 3);
    load(4, 16'h0020);
    load(3, 16'h0024);
    load(2, 16'(c));
    sw_load <= '0;
    e = fetch_addr;
    repeat (60) begin
      tick(1);
      if (e == 16'h0024 && c != 0) begin
        e = 16'h0020;
        c--;
      end else e++;
      check(fetch_addr, e[15:0]);
    end
    check(lp_cnt, 16'h0000);
    $display("loop test done");
    m = $urandom_range(0, 65535) & 16'hff7f;
    pg = $urandom_range(0, 65535);
    page_in <= 16'(pg);
    load(0, 16'(m));
    sw_load <= '0;
    want <= 1'b1;
    wait_busy(1'b1);
    f1 = fetch_addr;
    tick(1);
    check(fetch_addr, int_vector);
    tick(1);
    check(cancel_exec, 1'b1);
    c = 2;
    while (int_busy === 1'b1 && c < 20) begin
      tick(1);
      c++;
    end
    check(16'(c), 16'h0005);
    check(link, 16'(f1));
    check(spage, 16'(pg));
    check(mode, 16'(m | 16'h0080));
    check(smode, 16'(m | 16'h0080));
    load(1, 16'h0abc);
    wait_busy(1'b1);
    check(n >= 3, 1'b1);
    want <= 1'b0;
    wait_busy(1'b0);
    sw_load <= '0;
    tick(1);
    check(link, 16'h0abc);
    $display("cancelled entry test done");
    load(2, 16'h0002);
    load(3, 16'(fetch_addr + 8));
    sw_load <= '0;
    f1 = fetch_addr;
    tick(12);
    check(fetch_addr, 16'(f1 + 12));
    dec_class.vector_jump_cancel_slot <= 1'b1;
    tick(1);
    dec_class <= '0;
    tick(1);
    check(mode[7], 1'b1);
    end_op <= 16'(fetch_addr + 40);
    cnt_op <= 16'h0003;
    dec_class.loop_start <= 1'b1;
    tick(1);
    dec_class <= '0;
    tick(1);
    check(mode[7], 1'b0);
    check(lp_end, end_op);
    check(lp_cnt, 16'h0003);
    $display("inhibit test done");
    jump_target <= 16'h0200;
    jump_taken <= 1'b1;
    dec_class.jump <= 1'b1;
    want <= 1'b1;
    wait_busy(1'b1);
    tick(1);
    dec_class <= '0;
    jump_taken <= 1'b0;
    want <= 1'b0;
    c = 0;
    repeat (5) begin
      tick(1);
      if (cancel_exec !== 1'b0) c++;
    end
    check(16'(c), 16'h0000);
    check(link, 16'h0200);
    $display("kept entry test done");
    tally_and_finish();
  end
endmodule // hlie_seq_tb_top
